//--- nvsram_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// memory device model
// ----
module nvsram_dev_model (
  // controls
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic supply_ok,
  input wire logic [12:0] a,
  // host data side
  input wire logic [7:0] d_host,
  input wire logic d_host_en,
  output logic [7:0] dq
);
  logic [7:0] sram [0:8191];
  logic [7:0] nv [0:8191]; // shadow array
  int step = 0; // command detector step
  int n_save = 0;
  int n_restore = 0;
  int n_auto = 0; // automatic stores at power loss
  logic dirty = 1'b0; // written since last transfer
  logic rd; // device drives bus
  logic wr; // write in progress
  logic [12:0] seq [0:4];
  assign seq = '{13'h0000, 13'h1555, 13'h0AAA, 13'h1FFF, 13'h10F0};
  assign rd = !ce_n && !oe_n && we_n;
  assign wr = !ce_n && !we_n;
  // undriven bus shows inverse of the byte at the current address, not a stale copy
  always_comb begin
    if (d_host_en) dq = d_host;
    else if (rd) dq = sram[a];
    else dq = ~sram[a];
  end
  initial begin
    for (int i = 0; i < 8192; i++) nv[i] = i[7:0] ^ 8'h3C;
  end
  // byte lands at end of write
  always @(negedge wr) begin
    if (supply_ok) begin
      sram[a] = dq;
      dirty = 1'b1;
    end
    step = 0;
  end
  always @(posedge supply_ok) begin
    sram = nv;
    dirty = 1'b0;
  end
  // power loss keeps the shadow only if something changed
  always @(negedge supply_ok) begin
    if (dirty) begin
      nv = sram;
      n_auto++;
    end
    dirty = 1'b0;
  end
  // select-clocked command detector
  always @(negedge ce_n) begin
    if (!we_n) step = 0;
    else if (step == 5 && a[12:1] == 12'h787) begin
      if (a[0] && supply_ok) begin
        nv = sram;
        n_save++;
        dirty = 1'b0;
      end else if (!a[0]) begin
        sram = nv;
        n_restore++;
        dirty = 1'b0;
      end
      step = 0;
    end else if (step < 5 && a == seq[step]) step++;
    else step = (a == 13'h0000);
  end
endmodule : nvsram_dev_model
`default_nettype wire

//--- nvsram_host.sv
// What this block does
// - address held stable across write cycle
// - output enable kept high during writes
// - store command is six fixed reads
// - recall command ends with 0F0E read
// - each command step toggles chip select
// - command steps are reads only
// - write strobe high through all six
// - never hold write at power-up recall end
`timescale 1ns/100ps
`default_nettype none

module nvsram_host (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // user request
  input wire logic REQ_VALID,
  input wire logic [2:0] REQ_CMD,
  input wire logic [12:0] REQ_ADDR,
  input wire logic [7:0] REQ_WDATA,
  output logic REQ_READY,
  // user answer
  output logic RSP_VALID,
  output logic [7:0] RSP_RDATA,
  // supply status from board monitor
  input wire logic SUPPLY_OK,
  // memory pins
  output logic CHIP_SEL_N,
  output logic OUT_EN_N,
  output logic WRITE_N,
  output logic [12:0] ADDRESS_LINES,
  input wire logic [7:0] DATA_LINES_IN,
  output logic [7:0] DATA_LINES_OUT,
  output logic DATA_LINES_OE
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POWERUP, ST_IDLE, ST_SETUP, ST_ACTIVE, ST_GAP, ST_BUSY
  } state_t;

  state_t state_reg, state_next;
  logic [23:0] wait_reg, wait_next;     // shared cycle counter
  logic [2:0] kind_reg, kind_next;      // command in flight
  logic [2:0] step_reg, step_next;      // command read index
  logic [12:0] addr_reg, addr_next;
  logic [7:0] wdata_reg, wdata_next;
  logic cs_n_reg, cs_n_next;
  logic oe_n_reg, oe_n_next;
  logic we_n_reg, we_n_next;
  logic doe_reg, doe_next;
  logic ready_reg, ready_next;
  logic rvalid_reg, rvalid_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [12:0] seq_addr;                // table output
  logic [2:0] rom_step;                 // table index for next access
  logic rom_is_save;                    // last entry picks store
  logic is_cmd;

  // ------------------------------------------------------------
  // command address table
  // ------------------------------------------------------------
  // fed from registers and pins only, so the next-state process
  // never reads back a value it computes itself
  assign rom_step = (state_reg == ST_IDLE) ? 3'h0 : step_reg + 3'h1;
  assign rom_is_save = (state_reg == ST_IDLE) ?
                       (REQ_CMD == nvsram_host_pkg::CMD_SAVE) :
                       (kind_reg == nvsram_host_pkg::CMD_SAVE);

  nvsram_seq_rom u_rom (
    .step(rom_step),
    .is_save(rom_is_save),
    .addr(seq_addr)
  );

  assign is_cmd = (kind_reg == nvsram_host_pkg::CMD_SAVE) ||
                  (kind_reg == nvsram_host_pkg::CMD_RESTORE);

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    wait_next = wait_reg;
    kind_next = kind_reg;
    step_next = step_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    cs_n_next = cs_n_reg;
    oe_n_next = oe_n_reg;
    we_n_next = we_n_reg;
    doe_next = doe_reg;
    ready_next = 1'b0;
    rvalid_next = 1'b0;
    rdata_next = rdata_reg;
    unique case (state_reg)
      // supply must be up and recall time spent before any access
      ST_POWERUP: begin
        cs_n_next = 1'b1;
        we_n_next = 1'b1;
        if (!SUPPLY_OK) begin
          wait_next = '0;
        end else if (wait_reg >=
            24'(nvsram_host_pkg::POWERUP_RESTORE_CYCLES - 1)) begin
          state_next = ST_IDLE;
          ready_next = 1'b1;
        end else begin
          wait_next = wait_reg + 24'h0001;
        end
      end
      // take a request; every request refused while supply low
      ST_IDLE: begin
        ready_next = 1'b1;
        if (!SUPPLY_OK) begin
          ready_next = 1'b0;
          wait_next = '0;
          state_next = ST_POWERUP;
        end else if (REQ_VALID && ready_reg) begin
          ready_next = 1'b0;
          kind_next = REQ_CMD;
          step_next = 3'h0;
          wdata_next = REQ_WDATA;
          addr_next = REQ_ADDR;
          if (REQ_CMD == nvsram_host_pkg::CMD_SAVE ||
              REQ_CMD == nvsram_host_pkg::CMD_RESTORE) begin
            addr_next = seq_addr;
          end
          state_next = ST_SETUP;
        end
      end
      // address settles one cycle before chip select falls
      ST_SETUP: begin
        cs_n_next = 1'b0;
        wait_next = '0;
        if (kind_reg == nvsram_host_pkg::CMD_WRITE) begin
          we_n_next = 1'b0;
          oe_n_next = 1'b1;
          doe_next = 1'b1;
        end else begin
          we_n_next = 1'b1;
          oe_n_next = 1'b0;
        end
        state_next = ST_ACTIVE;
      end
      // hold pins; sample data at end of read
      ST_ACTIVE: begin
        wait_next = wait_reg + 24'h0001;
        if (wait_reg >= 24'(nvsram_host_pkg::ACCESS_CYCLES - 1)) begin
          cs_n_next = 1'b1;
          we_n_next = 1'b1;
          oe_n_next = 1'b1;
          if (kind_reg == nvsram_host_pkg::CMD_READ) begin
            rdata_next = DATA_LINES_IN;
          end
          state_next = ST_GAP;
        end
      end
      // address and data held one cycle past the rising edge
      ST_GAP: begin
        doe_next = 1'b0;
        wait_next = '0;
        if (is_cmd && step_reg != 3'(nvsram_host_pkg::SEQ_LEN - 1)) begin
          // back-to-back reads, nothing else interleaved
          step_next = step_reg + 3'h1;
          addr_next = seq_addr;
          state_next = ST_SETUP;
        end else if (is_cmd) begin
          state_next = ST_BUSY;
        end else begin
          rvalid_next = 1'b1;
          ready_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      // device ignores pins until the transfer ends
      ST_BUSY: begin
        wait_next = wait_reg + 24'h0001;
        if ((kind_reg == nvsram_host_pkg::CMD_SAVE &&
             wait_reg >= 24'(nvsram_host_pkg::SAVE_CYCLES - 1)) ||
            (kind_reg != nvsram_host_pkg::CMD_SAVE &&
             wait_reg >= 24'(nvsram_host_pkg::RESTORE_CYCLES - 1))) begin
          rvalid_next = 1'b1;
          ready_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_POWERUP;
      end
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= ST_POWERUP;
      wait_reg <= 24'h0000;
      kind_reg <= 3'h0;
      step_reg <= 3'h0;
      addr_reg <= 13'h0000;
      wdata_reg <= 8'h00;
      cs_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      doe_reg <= 1'b0;
      ready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      wait_reg <= wait_next;
      kind_reg <= kind_next;
      step_reg <= step_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      cs_n_reg <= cs_n_next;
      oe_n_reg <= oe_n_next;
      we_n_reg <= we_n_next;
      doe_reg <= doe_next;
      ready_reg <= ready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
    end
  end

  // ------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ------------------------------------------------------------
  assign REQ_READY = ready_reg;
  assign RSP_VALID = rvalid_reg;
  assign RSP_RDATA = rdata_reg;
  assign CHIP_SEL_N = cs_n_reg;
  assign OUT_EN_N = oe_n_reg;
  assign WRITE_N = we_n_reg;
  assign ADDRESS_LINES = addr_reg;
  assign DATA_LINES_OUT = wdata_reg;
  assign DATA_LINES_OE = doe_reg;

endmodule : nvsram_host

`default_nettype wire

//--- nvsram_host_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// pin checker
// ----
module nvsram_host_checker (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // user side
  input wire logic REQ_VALID,
  input wire logic [2:0] REQ_CMD,
  input wire logic REQ_READY,
  input wire logic RSP_VALID,
  input wire logic SUPPLY_OK,
  // memory pins
  input wire logic CHIP_SEL_N,
  input wire logic OUT_EN_N,
  input wire logic WRITE_N,
  input wire logic [12:0] ADDRESS_LINES,
  input wire logic DATA_LINES_OE
);
  int ok_reg; // cycles of good supply
  int ok_next;
  // saturate so the count never wraps
  always_comb begin
    ok_next = ok_reg;
    if (!SUPPLY_OK) ok_next = 0;
    else if (ok_reg < 20000) ok_next = ok_reg + 1;
  end
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) ok_reg <= 0;
    else ok_reg <= ok_next;
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  AST_WR_OE: assert property (!WRITE_N |-> OUT_EN_N)
    else $error("output enable low in write");
  AST_WR_CS: assert property (!WRITE_N |-> !CHIP_SEL_N)
    else $error("write strobe without select");
  AST_WR_DRV: assert property (!WRITE_N |-> DATA_LINES_OE)
    else $error("write without data drive");
  AST_ADDR: assert property (!CHIP_SEL_N |-> $stable(ADDRESS_LINES))
    else $error("address moved in access");
  AST_RD_LAT: assert property (REQ_VALID && REQ_READY &&
    REQ_CMD == nvsram_host_pkg::CMD_READ |-> ##5 RSP_VALID)
    else $error("read answer late");
  AST_BUSY: assert property (REQ_VALID && REQ_READY |=> !REQ_READY)
    else $error("ready while busy");
  AST_LOW: assert property (!SUPPLY_OK ##1 !SUPPLY_OK |-> !REQ_READY)
    else $error("ready at low supply");
  AST_CS: assert property ($fell(CHIP_SEL_N) |=>
    !CHIP_SEL_N ##1 CHIP_SEL_N)
    else $error("select pulse width");
  AST_PWR: assert property (REQ_READY |->
    ok_reg >= nvsram_host_pkg::POWERUP_RESTORE_CYCLES - 2)
    else $error("ready before restore time");
endmodule : nvsram_host_checker
bind nvsram_host nvsram_host_checker chk_i (.SYS_CLK(SYS_CLK),
  .RST_N(RST_N), .REQ_VALID(REQ_VALID), .REQ_CMD(REQ_CMD),
  .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .SUPPLY_OK(SUPPLY_OK),
  .CHIP_SEL_N(CHIP_SEL_N), .OUT_EN_N(OUT_EN_N), .WRITE_N(WRITE_N),
  .ADDRESS_LINES(ADDRESS_LINES), .DATA_LINES_OE(DATA_LINES_OE));
`default_nettype wire

//--- nvsram_host_pkg.sv
package nvsram_host_pkg;

  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;            // 20 MHz system clock
  localparam int SAVE_DURATION_MS = 10;         // nonvolatile store time
  localparam int RESTORE_DURATION_US = 20;      // software recall time
  localparam int POWERUP_RESTORE_DURATION_US = 550; // power-up recall time
  localparam int SAVE_CYCLES = SAVE_DURATION_MS * 1000000 / CLK_PERIOD_NS;
  localparam int RESTORE_CYCLES =
    (RESTORE_DURATION_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWERUP_RESTORE_CYCLES =
    (POWERUP_RESTORE_DURATION_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYCLES = 2;             // chip select low time

  // ------------------------------------------------------------
  // widths and command addresses
  // ------------------------------------------------------------
  localparam int ADDR_W = 13;                   // 8,192 bytes
  localparam int DATA_W = 8;
  localparam int WAIT_W = 24;
  localparam int SEQ_LEN = 6;
  localparam logic [12:0] SEQ_A0 = 13'h0000;
  localparam logic [12:0] SEQ_A1 = 13'h1555;
  localparam logic [12:0] SEQ_A2 = 13'h0AAA;
  localparam logic [12:0] SEQ_A3 = 13'h1FFF;
  localparam logic [12:0] SEQ_A4 = 13'h10F0;
  localparam logic [12:0] SEQ_SAVE = 13'h0F0F;
  localparam logic [12:0] SEQ_RESTORE = 13'h0F0E;

  // ------------------------------------------------------------
  // user commands
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_READ = 3'h0,
    CMD_WRITE = 3'h1,
    CMD_SAVE = 3'h2,
    CMD_RESTORE = 3'h3
  } cmd_t;

endpackage : nvsram_host_pkg

//--- nvsram_seq_rom.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// command address table, picks the last entry by command kind
// ------------------------------------------------------------
module nvsram_seq_rom (
  // lookup
  input wire logic [2:0] step,
  input wire logic is_save,
  output logic [12:0] addr
);

  // six fixed read addresses, last one selects store or recall
  always_comb begin
    unique case (step)
      3'h0: addr = nvsram_host_pkg::SEQ_A0;
      3'h1: addr = nvsram_host_pkg::SEQ_A1;
      3'h2: addr = nvsram_host_pkg::SEQ_A2;
      3'h3: addr = nvsram_host_pkg::SEQ_A3;
      3'h4: addr = nvsram_host_pkg::SEQ_A4;
      default: begin
        addr = is_save ? nvsram_host_pkg::SEQ_SAVE
                       : nvsram_host_pkg::SEQ_RESTORE;
      end
    endcase
  end

endmodule : nvsram_seq_rom

`default_nettype wire

//--- tb_nvsram_host.sv
`timescale 1ns/100ps
`default_nettype none
module tb_nvsram_host;
  logic SYS_CLK, RST_N, REQ_VALID, REQ_READY, RSP_VALID, SUPPLY_OK;
  logic CHIP_SEL_N, OUT_EN_N, WRITE_N, DATA_LINES_OE;
  logic [2:0] REQ_CMD;
  logic [12:0] REQ_ADDR, ADDRESS_LINES;
  logic [7:0] REQ_WDATA, RSP_RDATA, DATA_LINES_IN, DATA_LINES_OUT, d;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  int n;
  nvsram_host DUT (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .REQ_VALID(REQ_VALID), .REQ_CMD(REQ_CMD), .REQ_ADDR(REQ_ADDR),
    .REQ_WDATA(REQ_WDATA), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID),
    .RSP_RDATA(RSP_RDATA), .SUPPLY_OK(SUPPLY_OK), .CHIP_SEL_N(CHIP_SEL_N),
    .OUT_EN_N(OUT_EN_N), .WRITE_N(WRITE_N), .ADDRESS_LINES(ADDRESS_LINES),
    .DATA_LINES_IN(DATA_LINES_IN), .DATA_LINES_OUT(DATA_LINES_OUT),
    .DATA_LINES_OE(DATA_LINES_OE));
  nvsram_dev_model dev (.ce_n(CHIP_SEL_N), .oe_n(OUT_EN_N), .we_n(WRITE_N),
    .supply_ok(SUPPLY_OK), .a(ADDRESS_LINES), .d_host(DATA_LINES_OUT),
    .d_host_en(DATA_LINES_OE), .dq(DATA_LINES_IN));
  initial begin
    SYS_CLK = 0;
    forever #25 SYS_CLK = ~SYS_CLK;
  end
  // ----
  // helpers
  // ----
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  task automatic wait_rdy;
    n = 0;
    while (REQ_READY !== 1'b1 && n < 12000) begin
      @(posedge SYS_CLK);
      n++;
    end
    chk("ready", REQ_READY, 1);
  endtask : wait_rdy
  // one request, held until taken, then wait for the answer
  task automatic xfer(input logic [2:0] c, input logic [12:0] ad,
      input logic [7:0] wd);
    int k;
    @(posedge SYS_CLK);
    REQ_VALID <= 1'b1;
    REQ_CMD <= c;
    REQ_ADDR <= ad;
    REQ_WDATA <= wd;
    do @(posedge SYS_CLK); while (REQ_READY !== 1'b1);
    REQ_VALID <= 1'b0;
    k = 0;
    do begin
      @(posedge SYS_CLK);
      k++;
    end while (RSP_VALID !== 1'b1 && k < 1000);
    d = RSP_RDATA;
    chk("answer", k < 1000, 1);
  endtask : xfer
  // ----
  // scenarios
  // ----
  task sc_rw;
    xfer(3'h1, 13'h0000, 8'h5A);
    xfer(3'h1, 13'h1FFF, 8'h96);
    xfer(3'h0, 13'h0000, 8'h00);
    chk("rd0", d, 8'h5A);
    xfer(3'h0, 13'h1FFF, 8'h00);
    chk("rd1fff", d, 8'h96);
    xfer(3'h0, 13'h0123, 8'h00);
    chk("rd123", d, 8'h23 ^ 8'h3C);
  endtask : sc_rw
  task sc_supply;
    @(posedge SYS_CLK);
    SUPPLY_OK <= 1'b0;
    repeat (3) @(posedge SYS_CLK);
    chk("low_rdy", REQ_READY, 0);
    chk("auto1", dev.n_auto, 1);
    SUPPLY_OK <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    SUPPLY_OK <= 1'b0;
    repeat (3) @(posedge SYS_CLK);
    chk("auto2", dev.n_auto, 1);
    SUPPLY_OK <= 1'b1;
    wait_rdy();
    chk("pwr2", n >= nvsram_host_pkg::POWERUP_RESTORE_CYCLES - 2, 1);
    chk("we_idle", WRITE_N, 1);
    xfer(3'h0, 13'h0000, 8'h00);
    chk("rdrc", d, 8'h5A);
  endtask : sc_supply
  task sc_recall;
    xfer(3'h1, 13'h1FFF, 8'h11);
    xfer(3'h3, 13'h0000, 8'h00);
    xfer(3'h0, 13'h1FFF, 8'h00);
    chk("rcl", d, 8'h96);
    xfer(3'h3, 13'h0000, 8'h00);
    chk("nrcl", dev.n_restore, 2);
    xfer(3'h1, 13'h0040, 8'h77);
  endtask : sc_recall
  task sc_store;
    @(posedge SYS_CLK);
    REQ_VALID <= 1'b1;
    REQ_CMD <= 3'h2;
    do @(posedge SYS_CLK); while (REQ_READY !== 1'b1);
    REQ_VALID <= 1'b0;
    repeat (40) @(posedge SYS_CLK);
    chk("nsave", dev.n_save, 1);
    chk("nvbyte", dev.nv[13'h0040], 8'h77);
    chk("busy", REQ_READY, 0);
    RST_N <= 1'b0;
    repeat (20) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    wait_rdy();
    xfer(3'h0, 13'h0040, 8'h00);
    chk("after", d, 8'h77);
  endtask : sc_store
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 50000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    RST_N = 1'b0;
    REQ_VALID = 1'b0;
    REQ_CMD = 3'h0;
    REQ_ADDR = 13'h0000;
    REQ_WDATA = 8'h00;
    SUPPLY_OK = 1'b0;
    repeat (20) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    SUPPLY_OK <= 1'b1;
    wait_rdy();
    chk("pwr", n >= nvsram_host_pkg::POWERUP_RESTORE_CYCLES - 2, 1);
    sc_rw();
    sc_supply();
    sc_recall();
    sc_store();
    report_and_stop();
  end
endmodule : tb_nvsram_host
`default_nettype wire
